/* File: test/lsht_lin_master.sv */
// lin master node model driving the slave receive line
`default_nettype none
module lsht_lin_master (
	// clock
	input wire logic clk,
	// bus line, recessive high
	output logic lin
);
	timeunit 1ns;
	timeprecision 1ns;
	// pulled-up bus: recessive until the first frame
	initial lin = 1'b1;
	// hold a level for a count of sample ticks, one tick per clock
	task automatic level(input logic v, input int ticks);
		@(posedge clk);
		lin <= v;
		repeat (ticks - 1) @(posedge clk);
	endtask
	// 8n1 character lsb first; a low stop bit models a framing fault
	task automatic send_byte(input logic [7:0] b, input logic stop);
		level(1'b0, 16);
		for (int i = 0; i < 8; i++) level(b[i], 16);
		level(stop, 16);
		level(1'b1, 16);
	endtask
	// break, delimiter in ticks, synch and identifier
	task automatic send_header(input int brk, input int dlm, input logic [7:0] sy,
		input logic [7:0] id);
		level(1'b0, brk * 16);
		level(1'b1, dlm);
		send_byte(sy, 1'b1);
		send_byte(id, 1'b1);
	endtask
endmodule // lsht_lin_master
`default_nettype wire

/* File: test/lsht_top_sva.sv */
// port checker of the lin slave header block, bound to its top
`include "lsht_map.svh"
`default_nettype none
module lsht_top_sva (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire lsht_pkg::lsht_addr_t PADDR,
	input wire lsht_pkg::lsht_word_t PWDATA,
	input wire lsht_pkg::lsht_word_t PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// line and interrupt
	input wire logic LIN_RX,
	input wire logic IRQ
);
	import lsht_pkg::*;
	logic [1:0] mode_r;
	logic [2:0] mask_r;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	// ----
	// shadows
	// ----
	// software-owned bits only: hardware never touches them, so tracking is exact
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mode_r <= 2'h0;
			mask_r <= 3'h0;
		end else if (PSEL && PENABLE && PREADY && PWRITE) begin
			if (PADDR == `LSHT_OFF_CTRL) mode_r <= PWDATA[1:0];
			if (PADDR == `LSHT_OFF_IMASK) mask_r <= PWDATA[2:0];
		end
	end
	// ----
	// properties
	// ----
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_read(a);
		PSEL && PENABLE && PREADY && !PWRITE && PADDR == a;
	endsequence
	a_ready_one_wait: assert property (s_setup |-> ##2 PREADY)
		else $error("ready late after setup");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_unmapped: assert property (PREADY && PADDR > `LSHT_OFF_IMASK |-> PSLVERR)
		else $error("no error on unmapped address");
	a_write_zero: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
		else $error("read data on a write");
	a_flags_exclusive: assert property (s_read(`LSHT_OFF_STAT) |-> !(PRDATA[2] && PRDATA[3]))
		else $error("header error and header detected together");
	a_hlen_bounded: assert property (s_read(`LSHT_OFF_HLEN) |-> PRDATA < 32'h3a)
		else $error("header length above threshold");
	a_hlen_gated: assert property (s_read(`LSHT_OFF_HLEN) ##0 (mode_r == 2'h0) |-> PRDATA == 0)
		else $error("header length visible while gated");
	a_irq_follows: assert property (s_read(`LSHT_OFF_ISTAT) ##0 ((PRDATA[2:0] & mask_r) != 0)
		|=> IRQ)
		else $error("interrupt low with unmasked status");
	a_reset_quiet: assert property ($rose(RSTN) |-> !IRQ && !PREADY && !PSLVERR)
		else $error("outputs active at reset release");
endmodule // lsht_top_sva
bind lsht_top lsht_top_sva lsht_top_sva_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .LIN_RX(LIN_RX), .IRQ(IRQ));
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench of the lin slave header block
`include "lsht_map.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lsht_pkg::*;
	localparam lsht_addr_t ST = `LSHT_OFF_STAT, DT = `LSHT_OFF_DATA, CT = `LSHT_OFF_CTRL;
	localparam lsht_addr_t HL = `LSHT_OFF_HLEN, IS = `LSHT_OFF_ISTAT, IM = `LSHT_OFF_IMASK;
	logic clk, rstn, psel, penable, pwrite, lin, irq, pready, pslverr, err;
	lsht_addr_t paddr;
	lsht_word_t pwdata, prdata, v, seed;
	int bad_count, comparisons, cycles;
	lsht_top #(.DIV_RST(16'h0000)) lsht_top_i (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LIN_RX(lin), .IRQ(irq));
	lsht_lin_master lsht_lin_master_i (.clk(clk), .lin(lin));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard, far beyond the roughly 7k cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			finish_test();
		end
	end
	function automatic lsht_word_t lfsr(input lsht_word_t s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// whole bit periods from break start to the last identifier sample
	function automatic lsht_word_t exp_hlen(input int brk, input int dlm);
		return lsht_word_t'((brk * 16 + dlm + 336) / 16 - 1);
	endfunction
	task automatic chk(input string n, input lsht_word_t seen, input lsht_word_t exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// one apb transfer; waits on ready, bounded
	task automatic apb(input logic w, input lsht_addr_t a, input lsht_word_t d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		v = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("apb_ready", 32'h0, 32'h1);
	endtask
	task automatic rc(input lsht_addr_t a, input lsht_word_t m, input lsht_word_t e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, v & m, e);
	endtask
	// status read then data read, then acknowledge every interrupt bit
	task automatic clear_all();
		apb(1'b0, ST, 32'h0);
		apb(1'b0, DT, 32'h0);
		apb(1'b1, IS, 32'h7);
		rc(ST, '1, 32'h0, "stat_cleared");
		@(posedge clk);
		chk("irq_cleared", {31'h0, irq}, 32'h0);
	endtask
	task automatic finish_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		int brk[4] = '{40, 27, 27, 27};
		int dlm[4] = '{16, 164, 166, 168};
		logic [7:0] b;
		rstn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 32'h0947;
		{bad_count, comparisons, cycles} = '0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		// reset values, access kinds, unmapped address
		rc(CT, '1, 32'h0, "ctrl_reset");
		rc(IM, '1, 32'h0, "imask_reset");
		rc(HL, '1, 32'h0, "hlen_gated");
		seed = lfsr(seed);
		apb(1'b1, `LSHT_OFF_DIV, seed);
		rc(`LSHT_OFF_DIV, '1, {16'h0, seed[15:0]}, "div_rw");
		apb(1'b1, `LSHT_OFF_DIV, 32'h0);
		apb(1'b1, 8'h1c, seed);
		chk("unmapped_err", {31'h0, err}, 32'h1);
		apb(1'b1, CT, 32'h5);
		apb(1'b1, IM, 32'h7);
		// muted: framing fault and short break are dropped silently
		lsht_lin_master_i.send_byte(seed[23:16] | 8'h01, 1'b0);
		lsht_lin_master_i.send_header(10, 16, 8'h55, seed[7:0]);
		rc(ST, '1, 32'h0, "muted_stat");
		lsht_lin_master_i.send_header(13, 16, 8'h54, seed[7:0]);
		rc(ST, '1, 32'h1 << `LSHT_ST_HE, "bad_synch_stat");
		rc(CT, '1, 32'h5, "bad_synch_mute");
		clear_all();
		// time-outs, three of them landing late in the identifier stop bit
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			lsht_lin_master_i.send_header(brk[k], dlm[k], 8'h55, seed[7:0]);
			rc(ST, '1, 32'h1 << `LSHT_ST_HE, "tmo_stat");
			rc(HL, '1, 32'h0, "tmo_hlen");
			rc(IS, '1, 32'h1 << `LSHT_IRQ_HE, "tmo_istat");
			chk("tmo_irq", {31'h0, irq}, 32'h1);
			rc(CT, '1, 32'h5, "tmo_mute");
			if (v[`LSHT_CT_MUTE] !== 1'b1) apb(1'b1, CT, 32'h5);
			clear_all();
		end
		// good header on the shortest legal break wakes; length shown only with a mode bit
		seed = lfsr(seed);
		lsht_lin_master_i.send_header(11, 16, 8'h55, seed[7:0]);
		rc(ST, 32'he, 32'h1 << `LSHT_ST_HD, "hdr_stat");
		rc(IS, 32'h6, 32'h1 << `LSHT_IRQ_HD, "hdr_istat");
		rc(CT, '1, 32'h1, "hdr_wake");
		rc(HL, '1, exp_hlen(11, 16), "hlen_hdm");
		apb(1'b1, CT, 32'h0);
		rc(HL, '1, 32'h0, "hlen_off");
		apb(1'b1, CT, 32'h2);
		rc(HL, '1, exp_hlen(11, 16), "hlen_auto_resync_enable");
		clear_all();
		// unmuted: every byte received and flagged; the last has a bad stop bit
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			b = seed[7:0] | 8'h01;
			lsht_lin_master_i.send_byte(b, k != 3);
			rc(ST, 32'h2, {30'h0, k == 3, 1'b0}, "rx_ferr");
			if (k < 3) rc(ST, 32'h1, 32'h1, "rx_full");
			if (k < 3) rc(IS, 32'h1, 32'h1, "rx_istat");
			if (k < 3) rc(DT, 32'hff, {24'h0, b}, "rx_data");
			clear_all();
		end
		// masked event holds the interrupt low until the mask opens
		apb(1'b1, IM, 32'h6);
		lsht_lin_master_i.send_byte(seed[15:8], 1'b1);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		apb(1'b1, IM, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq_open", {31'h0, irq}, 32'h1);
		clear_all();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire

/* File: verilog/lsht_map.svh */
// register offsets, field positions, reset values and counts of the lin slave header block
`ifndef LSHT_MAP_SVH
`define LSHT_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LSHT_OFF_STAT 8'h00
`define LSHT_OFF_DATA 8'h04
`define LSHT_OFF_CTRL 8'h08
`define LSHT_OFF_DIV 8'h0c
`define LSHT_OFF_HLEN 8'h10
`define LSHT_OFF_ISTAT 8'h14
`define LSHT_OFF_IMASK 8'h18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSHT_ST_RXF 0
`define LSHT_ST_FE 1
`define LSHT_ST_HE 2
`define LSHT_ST_HD 3
`define LSHT_CT_HDM 0
`define LSHT_CT_AUTO_RESYNC_ENABLE 1
`define LSHT_CT_MUTE 2
`define LSHT_IRQ_RX 0
`define LSHT_IRQ_HE 1
`define LSHT_IRQ_HD 2
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define LSHT_DIV_RST 16'h0050
`define LSHT_SMP_MID 4'h7
`define LSHT_SMP_LAST 4'hf
`define LSHT_BIT_STOP 4'h9
`define LSHT_BREAK_BITS 6'h0b
`define LSHT_TIMEOUT_BITS 6'h39
`define LSHT_HLEN_SAT 6'h3a
`define LSHT_SYNCH_BYTE 8'h55
`endif

/* File: verilog/lsht_pkg.sv */
// shared types of the lin slave header block
`default_nettype none
package lsht_pkg;
	typedef logic [31:0] lsht_word_t;
	typedef logic [7:0] lsht_addr_t;
	typedef enum logic [1:0] {HS_IDLE, HS_BREAK, HS_SYNCH, HS_IDENT} lsht_hstate_t;
endpackage
`default_nettype wire

/* File: verilog/lsht_rx.sv */
// oversampling byte receiver, one start, eight data, one stop bit
`include "lsht_map.svh"
`default_nettype none
module lsht_rx (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// enable, sample tick and line
	input wire logic en,
	input wire logic tick,
	input wire logic rxd,
	// received byte
	output logic done,
	output logic [7:0] data,
	output logic ferr
);
	logic busy_r;
	logic [3:0] smp_r;
	logic [3:0] bit_r;

	// frame position; dropping enable aborts the byte under way
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			smp_r <= 4'h0;
			bit_r <= 4'h0;
		end else if (!en) begin
			busy_r <= 1'b0;
		end else if (tick) begin
			if (!busy_r) begin
				if (!rxd) begin
					busy_r <= 1'b1;
					smp_r <= 4'h1;
					bit_r <= 4'h0;
				end
			end else begin
				smp_r <= smp_r + 4'h1;
				if (smp_r == `LSHT_SMP_LAST) begin
					bit_r <= bit_r + 4'h1;
					if (bit_r == `LSHT_BIT_STOP)
						busy_r <= 1'b0;
				end
				// start bit gone by mid-bit: a glitch, not a frame
				if (smp_r == `LSHT_SMP_MID && bit_r == 4'h0 && rxd)
					busy_r <= 1'b0;
			end
		end
	end

	// data taken mid-bit, lsb first; done only at the last stop sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
			data <= 8'h00;
			ferr <= 1'b0;
		end else begin
			done <= 1'b0;
			if (en && tick && busy_r) begin
				if (smp_r == `LSHT_SMP_MID) begin
					if (bit_r == `LSHT_BIT_STOP)
						ferr <= ~rxd;
					else if (bit_r != 4'h0)
						data <= {rxd, data[7:1]};
				end
				if (smp_r == `LSHT_SMP_LAST && bit_r == `LSHT_BIT_STOP)
					done <= 1'b1;
			end
		end
	end
endmodule // lsht_rx
`default_nettype wire

/* File: verilog/lsht_tick.sv */
// sixteen-per-bit sample tick generator
`default_nettype none
module lsht_tick #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// divisor: tick period in clocks, minus one
	input wire logic [DW-1:0] div,
	// sample tick
	output logic tick
);
	logic [DW-1:0] cnt_r;

	// free-running divider; a lowered divisor takes effect at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r >= div) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // lsht_tick
`default_nettype wire

/* File: verilog/lsht_top.sv */
// lin slave receiver with header time-out, mute handling and apb registers
`include "lsht_map.svh"
`default_nettype none
module lsht_top #(
	parameter logic [15:0] DIV_RST = `LSHT_DIV_RST
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire lsht_pkg::lsht_addr_t PADDR,
	input wire lsht_pkg::lsht_word_t PWDATA,
	output var lsht_pkg::lsht_word_t PRDATA,
	output var logic PREADY,
	output var logic PSLVERR,
	// lin receive line
	input wire logic LIN_RX,
	// interrupt
	output var logic IRQ
);
	import lsht_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_r;
	logic [15:0] div_r;
	logic hdm_r;
	logic auto_resync_enable_r;
	logic mute_r;
	logic rxf_r;
	logic fe_r;
	logic he_r;
	logic hd_r;
	logic stat_rd_r;
	logic [7:0] data_r;
	logic [7:0] hlen_r;
	logic [2:0] istat_r;
	logic [2:0] imask_r;
	logic [2:0] irq_ev;
	logic tick;
	logic rx_en;
	logic rx_done;
	logic rx_ferr;
	logic [7:0] rx_data;
	lsht_hstate_t hs_r;
	lsht_hstate_t hs_nxt;
	logic [3:0] hsmp_r;
	logic [5:0] hbits_r;
	logic timed_out;
	logic hd_ev;
	logic he_ev;
	logic to_ev;
	logic byte_ev;
	logic clr_seq;
	logic acc;
	logic wr_fin;
	logic rd_fin;
	logic rd_hit;
	lsht_word_t rd_word;

	// address match, shared by the write and read decoders
	function automatic logic at(input lsht_addr_t a, input lsht_addr_t off);
		at = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// async assert, two-stage release so all flops leave reset together
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// sampling and byte reception
	// ----------------------------------------------------------------
	lsht_tick #(
		.DW(16)
	) u_tick (
		.clk(CLK_SYS),
		.rst_n(rst_n_r),
		.div(div_r),
		.tick(tick)
	);

	// muted: receiver only listens to the synch and identifier fields
	assign rx_en = ~mute_r | (hs_r == HS_SYNCH) | (hs_r == HS_IDENT);

	lsht_rx u_rx (
		.clk(CLK_SYS),
		.rst_n(rst_n_r),
		.en(rx_en),
		.tick(tick),
		.rxd(LIN_RX),
		.done(rx_done),
		.data(rx_data),
		.ferr(rx_ferr)
	);

	// ----------------------------------------------------------------
	// header length measurement
	// ----------------------------------------------------------------
	assign timed_out = (hbits_r > `LSHT_TIMEOUT_BITS);

	// whole bit periods since the break began; holds at the
	// saturation value so a stuck line cannot wrap it back under
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hsmp_r <= 4'h0;
			hbits_r <= 6'h00;
		end else if (hs_r == HS_IDLE) begin
			hsmp_r <= 4'h0;
			hbits_r <= 6'h00;
		end else if (tick) begin
			hsmp_r <= hsmp_r + 4'h1;
			if (hsmp_r == `LSHT_SMP_LAST && hbits_r != `LSHT_HLEN_SAT)
				hbits_r <= hbits_r + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// header state machine
	// ----------------------------------------------------------------
	// time-out is checked before any byte completion in the same cycle,
	// so an identifier finishing as the limit passes never wakes
	always_comb begin
		hs_nxt = hs_r;
		hd_ev = 1'b0;
		he_ev = 1'b0;
		to_ev = 1'b0;
		if (!(hdm_r | auto_resync_enable_r)) begin
			hs_nxt = HS_IDLE;
		end else begin
			case (hs_r)
				HS_IDLE: begin
					if (tick && !LIN_RX)
						hs_nxt = HS_BREAK;
				end
				HS_BREAK: begin
					if (timed_out) begin
						to_ev = 1'b1;
					end else if (tick && LIN_RX) begin
						// short low pulse is no break: drop it quietly. the rising
						// sample itself closes the last low bit, not yet counted
						if (hbits_r >= `LSHT_BREAK_BITS ||
								(hbits_r == `LSHT_BREAK_BITS - 6'h01 && hsmp_r == `LSHT_SMP_LAST))
							hs_nxt = HS_SYNCH;
						else
							hs_nxt = HS_IDLE;
					end
				end
				HS_SYNCH: begin
					if (timed_out) begin
						to_ev = 1'b1;
					end else if (rx_done) begin
						if (rx_data == `LSHT_SYNCH_BYTE && !rx_ferr)
							hs_nxt = HS_IDENT;
						else
							he_ev = 1'b1;
					end
				end
				HS_IDENT: begin
					if (timed_out) begin
						to_ev = 1'b1;
					end else if (rx_done) begin
						// parity of the identifier is not judged here
						if (rx_ferr)
							he_ev = 1'b1;
						else
							hd_ev = 1'b1;
					end
				end
				default: begin
					hs_nxt = HS_IDLE;
				end
			endcase
			if (to_ev)
				he_ev = 1'b1;
			if (he_ev)
				hs_nxt = HS_IDLE;
			if (hd_ev)
				hs_nxt = HS_IDLE;
		end
	end

	// state register
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			hs_r <= HS_IDLE;
		else
			hs_r <= hs_nxt;
	end

	// ----------------------------------------------------------------
	// mute control
	// ----------------------------------------------------------------
	// only a complete clean header wakes, and only while hdm_r is set; errors and time-outs leave
	// the receiver muted. a software write in the same cycle wins.
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			mute_r <= 1'b0;
		else if (wr_fin && at(PADDR, `LSHT_OFF_CTRL))
			mute_r <= PWDATA[`LSHT_CT_MUTE];
		else if (hd_ev && hdm_r)
			mute_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// received data and status flags
	// ----------------------------------------------------------------
	// bytes while muted are dropped, framing errors with them
	assign byte_ev = rx_done & ~mute_r;

	// clearing takes a status read followed by a data read
	assign clr_seq = rd_fin & at(PADDR, `LSHT_OFF_DATA) & stat_rd_r;

	// first half of the clearing sequence
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			stat_rd_r <= 1'b0;
		else if (rd_fin && at(PADDR, `LSHT_OFF_STAT))
			stat_rd_r <= 1'b1;
		else if (rd_fin && at(PADDR, `LSHT_OFF_DATA))
			stat_rd_r <= 1'b0;
	end

	// sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rxf_r <= 1'b0;
			fe_r <= 1'b0;
			he_r <= 1'b0;
			hd_r <= 1'b0;
		end else begin
			rxf_r <= byte_ev | (rxf_r & ~clr_seq);
			fe_r <= (byte_ev & rx_ferr) | (fe_r & ~clr_seq);
			he_r <= he_ev | (he_r & ~clr_seq);
			hd_r <= hd_ev | (hd_r & ~clr_seq & ~he_ev);
		end
	end

	// data holding register
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			data_r <= 8'h00;
		else if (byte_ev)
			data_r <= rx_data;
	end

	// header length: zero marks a time-out apart from other errors
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			hlen_r <= 8'h00;
		else if (to_ev)
			hlen_r <= 8'h00;
		else if (he_ev || hd_ev)
			hlen_r <= {2'b00, hbits_r};
	end

	// ----------------------------------------------------------------
	// configuration
	// ----------------------------------------------------------------
	// divisor sets the sample tick, hence the slave bit period
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div_r <= DIV_RST;
			hdm_r <= 1'b0;
			auto_resync_enable_r <= 1'b0;
		end else if (wr_fin && at(PADDR, `LSHT_OFF_DIV)) begin
			div_r <= PWDATA[15:0];
		end else if (wr_fin && at(PADDR, `LSHT_OFF_CTRL)) begin
			hdm_r <= PWDATA[`LSHT_CT_HDM];
			auto_resync_enable_r <= PWDATA[`LSHT_CT_AUTO_RESYNC_ENABLE];
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_comb begin
		irq_ev = 3'h0;
		irq_ev[`LSHT_IRQ_RX] = byte_ev;
		irq_ev[`LSHT_IRQ_HE] = he_ev;
		irq_ev[`LSHT_IRQ_HD] = hd_ev;
	end

	// write one to clear; event wins over a clear in the same cycle
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			istat_r <= 3'h0;
		else if (wr_fin && at(PADDR, `LSHT_OFF_ISTAT))
			istat_r <= irq_ev | (istat_r & ~PWDATA[2:0]);
		else
			istat_r <= irq_ev | istat_r;
	end

	// mask register
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			imask_r <= 3'h0;
		else if (wr_fin && at(PADDR, `LSHT_OFF_IMASK))
			imask_r <= PWDATA[2:0];
	end

	// registered level output, one cycle behind the status bits
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r)
			IRQ <= 1'b0;
		else
			IRQ <= |(istat_r & imask_r);
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// one wait state: ready in the second access cycle, data set up
	// in the first so it comes straight from a flop
	assign acc = PSEL & PENABLE;
	assign wr_fin = acc & PREADY & PWRITE;
	assign rd_fin = acc & PREADY & ~PWRITE;

	// read mux and decode
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		case (PADDR)
			`LSHT_OFF_STAT: begin
				rd_word[`LSHT_ST_RXF] = rxf_r;
				rd_word[`LSHT_ST_FE] = fe_r;
				rd_word[`LSHT_ST_HE] = he_r;
				rd_word[`LSHT_ST_HD] = hd_r;
			end
			`LSHT_OFF_DATA: begin
				rd_word[7:0] = data_r;
			end
			`LSHT_OFF_CTRL: begin
				rd_word[`LSHT_CT_HDM] = hdm_r;
				rd_word[`LSHT_CT_AUTO_RESYNC_ENABLE] = auto_resync_enable_r;
				rd_word[`LSHT_CT_MUTE] = mute_r;
			end
			`LSHT_OFF_DIV: begin
				rd_word[15:0] = div_r;
			end
			`LSHT_OFF_HLEN: begin
				if (hdm_r || auto_resync_enable_r)
					rd_word[7:0] = hlen_r;
			end
			`LSHT_OFF_ISTAT: begin
				rd_word[2:0] = istat_r;
			end
			`LSHT_OFF_IMASK: begin
				rd_word[2:0] = imask_r;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ready, read data and error flops
	always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
		if (!rst_n_r) begin
			PREADY <= 1'b0;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= acc & ~PREADY;
			PSLVERR <= acc & ~PREADY & ~rd_hit;
			if (acc && !PREADY)
				PRDATA <= PWRITE ? '0 : rd_word;
		end
	end
endmodule // lsht_top
`default_nettype wire
